/* File: common/tac_consts.svh */
// How it works
// - a command opens with a high start bit; low input before it is ignored
// - next start bit accepted from clock 15 (12-bit) or 11 (8-bit)
// - three bits after the start pick channel, driver switches and reference inputs
// - resolution bit low gives a 12-bit conversion, high gives 8 bits
// - reference mode bit high is single-ended, low is differential
// - single-ended uses the reference pins, differential uses driver switch voltage
// - power bits 00: sleep after each conversion, wake instantly, y-minus on, pen on
// - 01 reference off adc on, 10 reference on adc off, 11 all on, pen off
// - reference power is latched as busy rises; host sends an extra command
// - reference and converter power are independent; converter needs no wake-up
// - next command is taken while the current result still shifts out
// - a conversion paused by a stopped serial clock keeps full power
// - input sampled on rising serial clock, output updated after falling edge
// - serial data out driven only while chip select is low
// - busy rises after a falling edge and is driven only while chip select is low
// - acquisition from the last channel bit for four clocks, then conversion
// - chip select high powers down and abandons the conversion, keeps reference state
// - result is straight binary, most significant bit first
`ifndef TAC_CONSTS_SVH
`define TAC_CONSTS_SVH

`define TAC_CMD_LEN         8
`define TAC_POS_START       7
`define TAC_POS_CH_HI       6
`define TAC_POS_CH_LO       4
`define TAC_POS_RES         3
`define TAC_POS_REF         2
`define TAC_POS_PWR_HI      1
`define TAC_POS_PWR_LO      0
`define TAC_ACQ_BIT_CNT     3'd2
`define TAC_LAST_BIT_CNT    3'd6
`define TAC_BITS_12         4'd12
`define TAC_BITS_8          4'd8
`define TAC_MSB_12          4'd11
`define TAC_MSB_8           4'd7
`define TAC_NEXT_MIN_12     4'd7
`define TAC_NEXT_MIN_8      4'd3
`define TAC_PWR_AUTO        2'b00
`define TAC_PWR_REF_OFF     2'b01
`define TAC_PWR_ADC_OFF     2'b10
`define TAC_PWR_ALL_ON      2'b11

`endif

/* File: common/tac_pkg.sv */
package tac_pkg;

  typedef enum logic [0:0] {
    TAC_ST_IDLE = 1'b0,
    TAC_ST_CMD  = 1'b1
  } tac_cmd_state_e;

  typedef struct packed {
    logic [2:0] channel_select;
    logic       resolution_8bit;
    logic       reference_mode_select;
    logic       power_select_high;
    logic       power_select_low;
  } tac_cmd_s;

  typedef struct packed {
    logic adc_on;
    logic ref_on;
    logic pen_irq_en;
    logic ymin_on;
  } tac_power_s;

endpackage

/* File: verilog/tac_sync.sv */
`timescale 1ns/100ps
module tac_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second one
  always_ff @(posedge clk)
  begin
    meta_reg <= din;
    dout     <= meta_reg;
  end

endmodule

/* File: verilog/tac_sar.sv */
`timescale 1ns/100ps
`include "tac_consts.svh"
module tac_sar
  import tac_pkg::*;
#(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         cs_n,
  input  wire logic         start,
  input  wire logic         step,
  input  wire logic         bits8,
  input  wire logic         cmp,
  output logic      [W-1:0] trial,
  output logic      [W-1:0] result,
  output logic              bit_out
);

  logic [3:0] pos_reg;

  function automatic logic [W-1:0] bit_mask(input logic [3:0] p);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < W; i++)
      m[i] = (p == 4'(i));
    return m;
  endfunction

  wire [3:0]   msb_pos    = bits8 ? `TAC_MSB_8 : `TAC_MSB_12;
  wire [W-1:0] decided    = result | (cmp ? bit_mask(pos_reg) : '0);
  wire [3:0]   pos_dn     = pos_reg - 4'd1;
  wire [W-1:0] trial_step = (pos_reg == 4'd0) ? decided : (decided | bit_mask(pos_dn));

  // msb decided first, so bits leave in straight binary order
  always_ff @(posedge clk or posedge cs_n)
  begin
    if (cs_n)
    begin
      pos_reg <= 4'h0;
      trial   <= '0;
      result  <= '0;
      bit_out <= 1'b0;
    end
    else if (start)
    begin
      pos_reg <= msb_pos;
      trial   <= bit_mask(msb_pos);
      result  <= '0;
      bit_out <= 1'b0;
    end
    else if (step)
    begin
      pos_reg <= pos_dn;
      trial   <= trial_step;
      result  <= decided;
      bit_out <= cmp;
    end
  end

endmodule

/* File: verilog/tac_serial_ctrl.sv */
`timescale 1ns/100ps
`include "tac_consts.svh"
module tac_serial_ctrl
  import tac_pkg::*;
#(
  parameter int RES_W = 12
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             serial_clock,
  input  wire logic             cs_n,
  input  wire logic             sdi,
  input  wire logic             compare_in,
  output logic                  sdo,
  output logic                  sdo_oe,
  output logic                  busy,
  output logic                  busy_oe,
  output logic      [RES_W-1:0] sar_trial,
  output logic                  sample_acquire,
  output logic                  diff_reference,
  output tac_cmd_s              conv_cfg,
  output tac_power_s            power_state,
  output logic      [RES_W-1:0] result_data,
  output logic                  result_valid
);

  // link side: serial_clock domain, cleared whenever cs_n is high
  tac_cmd_state_e   cmd_state_reg;
  tac_cmd_state_e   cmd_state_next;
  logic [2:0]       bit_cnt_reg;
  logic [5:0]       cmd_shift_reg;
  tac_cmd_s         cmd_reg;
  logic             conv_active_reg;
  logic [3:0]       conv_cnt_reg;
  logic             acq_reg;
  logic             conv_done_reg;
  logic             busy_flag_reg;
  logic             bit_ready_reg;
  logic             cmp_sync;
  logic [RES_W-1:0] sar_result;
  logic             sar_bit;

  function automatic tac_cmd_s decode_cmd(input logic [`TAC_CMD_LEN-1:0] b);
    tac_cmd_s c;
    c.channel_select        = b[`TAC_POS_CH_HI:`TAC_POS_CH_LO];
    c.resolution_8bit       = b[`TAC_POS_RES];
    c.reference_mode_select = b[`TAC_POS_REF];
    c.power_select_high     = b[`TAC_POS_PWR_HI];
    c.power_select_low      = b[`TAC_POS_PWR_LO];
    return c;
  endfunction

  wire       in_cmd     = (cmd_state_reg == TAC_ST_CMD);
  wire [3:0] next_min   = cmd_reg.resolution_8bit ? `TAC_NEXT_MIN_8 : `TAC_NEXT_MIN_12;
  wire       start_ok   = !conv_active_reg || (conv_cnt_reg >= next_min);
  wire       take_start = !in_cmd && sdi && start_ok;
  wire       cmd_last   = in_cmd && (bit_cnt_reg == `TAC_LAST_BIT_CNT);
  wire       acq_begin  = in_cmd && (bit_cnt_reg == `TAC_ACQ_BIT_CNT);
  wire [7:0] cmd_byte   = {1'b1, cmd_shift_reg, sdi};
  tac_cmd_s  cmd_new;
  assign cmd_new = decode_cmd(cmd_byte);

  wire [3:0] conv_bits  = cmd_reg.resolution_8bit ? `TAC_BITS_8 : `TAC_BITS_12;
  wire       conv_step  = conv_active_reg && !cmd_last;
  wire [3:0] conv_cnt_inc = conv_cnt_reg + 4'd1;
  wire       conv_end   = conv_step && (conv_cnt_inc == conv_bits);

  always_comb
  begin
    cmd_state_next = cmd_state_reg;
    case (cmd_state_reg)
      TAC_ST_IDLE:
      begin
        if (take_start)
          cmd_state_next = TAC_ST_CMD;
      end
      TAC_ST_CMD:
      begin
        if (cmd_last)
          cmd_state_next = TAC_ST_IDLE;
      end
      default:
        cmd_state_next = TAC_ST_IDLE;
    endcase
  end

  wire [2:0] bit_cnt_next   = take_start ? 3'd0 : (in_cmd ? bit_cnt_reg + 3'd1 : bit_cnt_reg);
  wire [5:0] cmd_shift_next = in_cmd ? {cmd_shift_reg[4:0], sdi} : cmd_shift_reg;
  wire       acq_next       = acq_begin ? 1'b1 : (cmd_last ? 1'b0 : acq_reg);
  wire       active_next    = cmd_last ? 1'b1 : (conv_end ? 1'b0 : conv_active_reg);
  wire [3:0] conv_cnt_next  = cmd_last ? 4'd0 : (conv_step ? conv_cnt_inc : conv_cnt_reg);
  wire       done_next      = cmd_last ? 1'b0 : (conv_end ? 1'b1 : conv_done_reg);

  // input taken on the rising edge only
  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      cmd_state_reg <= TAC_ST_IDLE;
    else
      cmd_state_reg <= cmd_state_next;
  end

  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      bit_cnt_reg <= 3'd0;
    else
      bit_cnt_reg <= bit_cnt_next;
  end

  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      cmd_shift_reg <= 6'h00;
    else
      cmd_shift_reg <= cmd_shift_next;
  end

  // held for the whole conversion, so the clock side copies it without a handshake
  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      cmd_reg <= '0;
    else
      cmd_reg <= cmd_last ? cmd_new : cmd_reg;
  end

  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      conv_active_reg <= 1'b0;
    else
      conv_active_reg <= active_next;
  end

  // counts conversion clocks; it also spaces the next start bit
  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      conv_cnt_reg <= 4'h0;
    else
      conv_cnt_reg <= conv_cnt_next;
  end

  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      acq_reg <= 1'b0;
    else
      acq_reg <= acq_next;
  end

  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      conv_done_reg <= 1'b0;
    else
      conv_done_reg <= done_next;
  end

  // busy is a one-clock echo of the command's last bit
  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      busy_flag_reg <= 1'b0;
    else
      busy_flag_reg <= cmd_last;
  end

  always_ff @(posedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      bit_ready_reg <= 1'b0;
    else
      bit_ready_reg <= conv_step;
  end

  tac_sync #(
    .W(1)
  ) u_cmp_sync (
    .clk  (serial_clock),
    .din  (compare_in),
    .dout (cmp_sync)
  );

  tac_sar #(
    .W(RES_W)
  ) u_sar (
    .clk     (serial_clock),
    .cs_n    (cs_n),
    .start   (cmd_last),
    .step    (conv_step),
    .bits8   (cmd_new.resolution_8bit),
    .cmp     (cmp_sync),
    .trial   (sar_trial),
    .result  (sar_result),
    .bit_out (sar_bit)
  );

  // outputs move half a serial clock after the rising edge
  always_ff @(negedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      busy <= 1'b0;
    else
      busy <= busy_flag_reg;
  end

  always_ff @(negedge serial_clock or posedge cs_n)
  begin
    if (cs_n)
      sdo <= 1'b0;
    else
      sdo <= bit_ready_reg & sar_bit;
  end

  // system side: clock domain
  logic s_cs_n;
  logic s_act;
  logic s_acq;
  logic s_done;
  logic act_prev_reg;
  logic done_prev_reg;
  logic ref_on_reg;

  tac_sync #(
    .W(4)
  ) u_sys_sync (
    .clk  (clock),
    .din  ({cs_n, conv_active_reg, acq_reg, conv_done_reg}),
    .dout ({s_cs_n, s_act, s_acq, s_done})
  );

  // cmd_reg is held steady for the whole conversion, so the synced
  // active level acts as the handshake for the word
  wire       act_rise  = s_act & ~act_prev_reg;
  wire       done_rise = s_done & ~done_prev_reg;
  tac_cmd_s  cfg_next;
  assign cfg_next = act_rise ? cmd_reg : conv_cfg;
  wire [1:0] pwr_sel   = {cfg_next.power_select_high, cfg_next.power_select_low};
  wire       pwr_auto  = (pwr_sel == `TAC_PWR_AUTO);
  wire       adc_keep  = (pwr_sel == `TAC_PWR_REF_OFF) || (pwr_sel == `TAC_PWR_ALL_ON);
  // a paused conversion still counts as active, so power stays up
  wire       adc_next  = !s_cs_n && (s_act || s_acq || adc_keep);
  // reference only follows a new conversion, never chip select
  wire       ref_next  = act_rise ? cfg_next.power_select_high : ref_on_reg;
  wire       pen_next  = (pwr_sel != `TAC_PWR_ALL_ON);
  wire       ymin_next = pwr_auto && !adc_next;
  wire       diff_next = !cfg_next.reference_mode_select;
  tac_power_s power_next;
  assign power_next = '{adc_on: adc_next, ref_on: ref_next,
                        pen_irq_en: pen_next, ymin_on: ymin_next};

  // resetn is synchronous and reaches only this side; link flops rely on cs_n
  always_ff @(posedge clock)
  begin
    if (!resetn)
      act_prev_reg <= 1'b0;
    else
      act_prev_reg <= s_act;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      done_prev_reg <= 1'b0;
    else
      done_prev_reg <= s_done;
  end

  // reference survives cs_n; only resetn or a new conversion with power_select_high low turns it off
  always_ff @(posedge clock)
  begin
    if (!resetn)
      ref_on_reg <= 1'b0;
    else
      ref_on_reg <= ref_next;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      conv_cfg <= '0;
    else
      conv_cfg <= cfg_next;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      power_state <= '0;
    else
      power_state <= power_next;
  end

  // enables trail the pin by two to three clocks through the synchroniser
  always_ff @(posedge clock)
  begin
    if (!resetn)
      sdo_oe <= 1'b0;
    else
      sdo_oe <= !s_cs_n;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      busy_oe <= 1'b0;
    else
      busy_oe <= !s_cs_n;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      sample_acquire <= 1'b0;
    else
      sample_acquire <= s_acq && !s_cs_n;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      diff_reference <= 1'b0;
    else
      diff_reference <= diff_next;
  end

  // sar_result stands still for three serial clocks after done, ample for the copy
  always_ff @(posedge clock)
  begin
    if (!resetn)
      result_data <= '0;
    else
      result_data <= done_rise ? sar_result : result_data;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      result_valid <= 1'b0;
    else
      result_valid <= done_rise;
  end

endmodule

/* File: dv/tac_sva.sv */
`timescale 1ns/100ps
module tac_sva
  import tac_pkg::*;
(
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       cs_n,
  input wire logic       sdo,
  input wire logic       sdo_oe,
  input wire logic       busy,
  input wire logic       busy_oe,
  input wire logic       sample_acquire,
  input wire logic       diff_reference,
  input wire tac_cmd_s   conv_cfg,
  input wire tac_power_s power_state,
  input wire logic       result_valid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // oe comes from a two-flop sync, so allow the sync delay before judging
  a_oe_pair: assert property (sdo_oe == busy_oe) else $error("oe pair");
  a_oe_off: assert property (cs_n [*4] |-> !sdo_oe) else $error("oe stuck");
  a_oe_on: assert property (!cs_n [*5] |-> busy_oe) else $error("oe late");
  a_pins_idle: assert property (cs_n |-> !sdo && !busy) else $error("link live");
  a_acq_idle: assert property (cs_n [*4] |-> !sample_acquire) else $error("acq");
  a_ref_hold: assert property (cs_n [*6] |-> $stable(power_state.ref_on))
    else $error("ref moved");
  a_ref_latch: assert property ($changed(conv_cfg) ##1 $stable(conv_cfg) [*3]
    |-> power_state.ref_on == conv_cfg.power_select_high) else $error("ref");
  a_diff_map: assert property ($changed(conv_cfg) ##1 $stable(conv_cfg) [*3]
    |-> diff_reference != conv_cfg.reference_mode_select) else $error("diff");
  a_pen_map: assert property ($changed(conv_cfg) ##1 $stable(conv_cfg) [*3]
    |-> power_state.pen_irq_en != (conv_cfg.power_select_high
    && conv_cfg.power_select_low)) else $error("pen");
  a_valid_pulse: assert property (result_valid |=> !result_valid) else $error("vld");
  a_adc_down: assert property (cs_n [*4] |-> !power_state.adc_on)
    else $error("adc on");
  a_acq_power: assert property (sample_acquire |-> power_state.adc_on)
    else $error("adc off");
endmodule
bind tac_serial_ctrl tac_sva tac_sva_inst (.clock, .resetn, .cs_n, .sdo, .sdo_oe, .busy,
  .busy_oe, .sample_acquire, .diff_reference, .conv_cfg, .power_state, .result_valid);

/* File: dv/tac_host.sv */
`timescale 1ns/100ps
module tac_host (
  output logic      serial_clock,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo_pin,
  input  wire logic busy_pin
);
  logic smp_sdo [0:63];
  logic smp_busy [0:63];
  initial
  begin
    serial_clock = 1'b0;
    cs_n = 1'b0;
    sdi = 1'b0;
    // a clean rising cs_n clears the link flops, which have no other reset
    #1 cs_n = 1'b1;
  end
  // idle sdi keeps moving so a leaky start detector shows up
  always #230
    if (cs_n)
      sdi = ~sdi;
  // clock parked low between frames; frames stay far below the droop limit
  task automatic frame(input logic [63:0] bits, input int len);
    cs_n = 1'b0;
    #103;
    for (int k = 0; k < len; k++)
    begin
      sdi = bits[63-k];
      #80 serial_clock = 1'b1;
      smp_sdo[k] = sdo_pin;
      smp_busy[k] = busy_pin;
      #80 serial_clock = 1'b0;
    end
    #100 cs_n = 1'b1;
  endtask
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import tac_pkg::*;
;
  localparam logic [2:0] TOUCH_CH = 3'h1;  // stand-in code for a touch channel
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        compare_in = 1'b0;
  wire         serial_clock, cs_n, sdi, sdo, sdo_oe, busy, busy_oe, diff_reference;
  wire         result_valid;
  wire         sample_acquire;
  wire  [11:0] sar_trial;
  wire  [11:0] result_data;
  tac_cmd_s    conv_cfg;
  tac_power_s  power_state;
  wire         sdo_pin = sdo_oe ? sdo : 1'bz;
  wire         busy_pin = busy_oe ? busy : 1'bz;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          nvalid = 0;
  integer      seed = 94568;
  logic [63:0] stm;
  logic [7:0]  cfg = 8'h00;
  logic [11:0] res = 12'h000;
  int          lead, sp;

  tac_serial_ctrl tac_serial_ctrl_inst (.clock, .resetn, .serial_clock, .cs_n, .sdi,
    .compare_in, .sdo, .sdo_oe, .busy, .busy_oe, .sar_trial, .sample_acquire,
    .diff_reference, .conv_cfg, .power_state, .result_data, .result_valid);
  tac_host tac_host_inst (.serial_clock, .cs_n, .sdi, .sdo_pin, .busy_pin);

  always #5 clock = ~clock;

  task automatic give_verdict;
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (result_valid === 1'b1)
      nvalid++;
    if (cycles == 30000)
    begin
      num_errors++;
      $display("unexpected at %0t: run hung", $time);
      give_verdict();
    end
  end

  // differential only on the touch channel
  function automatic logic [7:0] mkc(input logic [1:0] pwr);
    logic [7:0] v;
    v = 8'($random(seed));
    v[7] = 1'b1;
    v[1:0] = pwr;
    if (!v[2])
      v[6:4] = TOUCH_CH;
    return v;
  endfunction

  // model walks the stream the way the device should, then the frame is compared
  task automatic run(input int len, input logic cmp);
    logic       e_sdo [0:63];
    logic       e_bsy [0:63];
    logic [7:0] m;
    int         p, nv, done;
    p = 0;
    done = 0;
    for (int k = 0; k < 64; k++)
    begin
      e_sdo[k] = 1'b0;
      e_bsy[k] = 1'b0;
    end
    while (p < len)
      if (stm[63-p] !== 1'b1)
        p++;
      else
      begin
        m = stm[63-p -: 8];
        if (p + 8 <= len)
          cfg = m;
        e_bsy[p+8] = 1'b1;
        for (int k = 0; k < (m[3] ? 8 : 12); k++)
          e_sdo[p+9+k] = cmp;
        if (p + (m[3] ? 16 : 20) <= len)
        begin
          done++;
          res = cmp ? (m[3] ? 12'h0ff : 12'hfff) : 12'h000;
        end
        p += m[3] ? 11 : 15;
      end
    @(negedge clock);
    compare_in = cmp;
    nv = nvalid;
    tac_host_inst.frame(stm, len);
    repeat (8) @(negedge clock);
    for (int k = 0; k < len; k++)
    begin
      check(12'(tac_host_inst.smp_sdo[k]), 12'(e_sdo[k]), "sdo");
      check(12'(tac_host_inst.smp_busy[k]), 12'(e_bsy[k]), "busy");
    end
    check(12'(conv_cfg), 12'(cfg[6:0]), "cfg");
    check(12'(diff_reference), 12'(!cfg[2]), "diff");
    check(12'(power_state.ref_on), 12'(cfg[1]), "ref");
    check(12'(power_state.pen_irq_en), 12'(cfg[1:0] != 2'b11), "pen");
    check(result_data, res, "result");
    check(12'(nvalid - nv), 12'(done), "count");
    check(sar_trial, 12'h000, "trial");
    check(12'(sample_acquire), 12'h000, "acquire");
    check(12'(power_state.adc_on), 12'h000, "adc");
    check(12'(power_state.ymin_on), 12'(cfg[1:0] == 2'b00), "ymin");
  endtask

  initial
  begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      stm = 64'h0;
      lead = $random(seed) & 3;
      stm[63-lead -: 8] = mkc(2'(i));
      sp = (i % 3 == 0) ? 24 : (stm[59-lead] ? 11 : 15);
      stm[63-lead-sp -: 8] = mkc(2'(i + 1));
      run((i == 6) ? lead + 13 : lead + sp + 24, 1'($random(seed)));
    end
    give_verdict();
  end
endmodule
